// ===== rtl/ucnt_pkg.sv
// Shared constants and types for the up/down counter and its control driver
package ucnt_pkg;
	localparam int MAX_W = 125;
	localparam int DEF_W = 8;
	localparam int DEF_FRAC = 0;
	localparam int DEF_SAMPLE = 1;
	localparam int PERIOD_W = 16;
	localparam logic [MAX_W-1:0] DEF_INIT = 125'h0;
	localparam logic [MAX_W-1:0] DEF_STEP = 125'h1;
	localparam logic [MAX_W-1:0] DEF_TERM = 125'h64;
	localparam int MIN_W_UNSIGNED = 1;
	localparam int MIN_W_SIGNED = 2;
	// Driver register map, byte addresses on APB
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PRESET = 8'h04;
	localparam logic [7:0] OFF_PERIOD = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0C;
	// Control register fields
	localparam int CTRL_CLR = 0;
	localparam int CTRL_PRE = 1;
	localparam int CTRL_GATE = 2;
	localparam int CTRL_DIR = 3;
	localparam logic [31:0] CTRL_RST = 32'h0000000C;
	localparam logic [31:0] PRESET_RST = 32'h00000000;
	localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0001;
	typedef enum logic [1:0] {
		UCNT_FREE = 2'b01,
		UCNT_LIMITED = 2'b10
	} ucnt_mode_t;
endpackage

// ===== rtl/ucnt_if.sv
// Connection between the counter and the logic that drives its control inputs
`timescale 1ns/1ns
interface ucnt_if #(
	parameter int W = ucnt_pkg::DEF_W
) ();
	logic clear;
	logic preset;
	logic [W-1:0] preset_val;
	logic gate;
	logic dir;
	logic sample_tick;
	logic [W-1:0] count;
	modport dev (input clear, input preset, input preset_val, input gate, input dir, input sample_tick,
		output count);
	modport drv (output clear, output preset, output preset_val, output gate, output dir, output sample_tick,
		input count);
endinterface

// ===== rtl/ucnt_tick.sv
// Sample period generator: one-cycle tick every period clocks
`timescale 1ns/1ns
module ucnt_tick #(
	parameter int PW = ucnt_pkg::PERIOD_W
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic [PW-1:0] period, // Clocks per sample, 0 acts as 1
	output logic tick // One-cycle sample pulse
);
	typedef struct packed {
		logic [PW-1:0] cnt;
		logic tick;
	} ucnt_tick_st_t;
	ucnt_tick_st_t s_q;
	ucnt_tick_st_t s_d;

	always_comb
	begin
		s_d = s_q;
		if ((s_q.cnt + PW'(1)) >= period)
		begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end
		else
		begin
			s_d.cnt = s_q.cnt + PW'(1);
			s_d.tick = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick = s_q.tick;
endmodule // ucnt_tick

// ===== rtl/ucnt_counter.sv
// Counter end: steps a count by a fixed amount once per sample period
`timescale 1ns/1ns
// Overview of operation
// - Reset and limit match load initial value
// - Local clear restores initial value
// - Preset strobe loads preset value, same type
// - Gate low holds count, high resumes
// - Direction high adds the step
// - Direction low subtracts the step
// - No direction input: always add step
// - Priority: clear, preset, gate, direction
// - Width parameter, default 8, max 125
// - Fraction length parameter, default 0
// - Signedness parameter, default unsigned
// - Mode parameter, free running by default
// - Step default 1, initial default 0
// - Step nonzero and representable in type
// - Reload on exact match, default 100
// - Terminal value should differ from initial
// - Own period alone, else inputs' period
// - Each control input optional, default absent
// - Overflow and underflow wrap around
// - Matching count makes initial value next
// - Control inputs sampled on clock edge
// - All control inputs active high
module ucnt_counter #(
	parameter int W = ucnt_pkg::DEF_W, // Word length with sign
	parameter int FRAC = ucnt_pkg::DEF_FRAC, // Bits right of binary point
	parameter bit SIGNED = 1'b0, // Signed count when set
	parameter ucnt_pkg::ucnt_mode_t MODE = ucnt_pkg::UCNT_FREE, // Counting mode
	parameter logic [ucnt_pkg::MAX_W-1:0] INIT = ucnt_pkg::DEF_INIT, // Initial value
	parameter logic [ucnt_pkg::MAX_W-1:0] STEP = ucnt_pkg::DEF_STEP, // Step, two's complement
	parameter logic [ucnt_pkg::MAX_W-1:0] TERM = ucnt_pkg::DEF_TERM, // Terminal value
	parameter bit HAS_CLR = 1'b0, // Local clear input present
	parameter bit HAS_PRE = 1'b0, // Preset inputs present
	parameter bit HAS_GATE = 1'b0, // Count gate present
	parameter bit HAS_DIR = 1'b0, // Direction select present
	parameter int SAMPLE = ucnt_pkg::DEF_SAMPLE // Own sample period in clocks
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Global async reset, active low
	ucnt_if.dev bus, // Control inputs and count
	output logic [W-1:0] count, // Present count
	output logic wrapped, // Pulse: last step overflowed
	output logic reloaded, // Pulse: terminal match reloaded
	output logic cfg_bad // Level: configuration out of range
);
	localparam bit HAS_ANY = HAS_CLR | HAS_PRE | HAS_GATE | HAS_DIR;
	localparam int W_MIN = SIGNED ? ucnt_pkg::MIN_W_SIGNED : ucnt_pkg::MIN_W_UNSIGNED;
	localparam int FRAC_BITS = FRAC;
	localparam logic [W-1:0] INIT_W = INIT[W-1:0];
	localparam logic [W-1:0] STEP_W = STEP[W-1:0];
	localparam logic [W-1:0] TERM_W = TERM[W-1:0];
	localparam logic [W-1:0] MOST_NEG = {1'b1, {(W-1){1'b0}}};
	localparam bit LIMITED = (MODE == ucnt_pkg::UCNT_LIMITED);
	localparam logic [ucnt_pkg::PERIOD_W-1:0] SAMPLE_P = SAMPLE[ucnt_pkg::PERIOD_W-1:0];
	// Step of zero, most negative signed step, bad width, or limit equal to start
	localparam bit BAD = (STEP_W == '0) || (SIGNED && STEP_W == MOST_NEG) || (W < W_MIN)
		|| (W > ucnt_pkg::MAX_W) || (FRAC_BITS < 0) || (LIMITED && TERM_W == INIT_W);

	typedef struct packed {
		logic [W-1:0] count;
		logic wrapped;
		logic reloaded;
		logic cfg_bad;
	} ucnt_cnt_st_t;
	ucnt_cnt_st_t s_q;
	ucnt_cnt_st_t s_d;

	// One-hot step action chosen each cycle
	typedef enum logic [6:0] {
		ACT_IDLE = 7'b0000001,
		ACT_CLEAR = 7'b0000010,
		ACT_LOAD = 7'b0000100,
		ACT_HOLD = 7'b0001000,
		ACT_RELOAD = 7'b0010000,
		ACT_ADD = 7'b0100000,
		ACT_SUB = 7'b1000000
	} ucnt_act_t;
	ucnt_act_t act;

	logic own_tick;
	logic sample;
	logic clr_in;
	logic pre_in;
	logic gate_in;
	logic up_in;

	// Overflow of a W-bit step, unsigned by carry/borrow, signed by sign change
	function automatic logic step_wraps(input logic [W-1:0] a, input logic [W-1:0] b, input logic add);
		logic [W:0] ext;
		logic ovf;
		ext = add ? ({1'b0, a} + {1'b0, b}) : ({1'b0, a} - {1'b0, b});
		ovf = 1'b0;
		if (SIGNED)
		begin
			if (add)
				ovf = (a[W-1] == b[W-1]) && (ext[W-1] != a[W-1]);
			else
				ovf = (a[W-1] != b[W-1]) && (ext[W-1] != a[W-1]);
		end
		else
			ovf = ext[W];
		return ovf;
	endfunction

	// Fixed priority: clear, preset, gate, terminal reload, direction
	function automatic ucnt_act_t pick_action(input logic smp, input logic clr, input logic pre, input logic gte,
		input logic hit, input logic up);
		ucnt_act_t a;
		if (!smp)
			a = ACT_IDLE;
		else if (clr)
			a = ACT_CLEAR;
		else if (pre)
			a = ACT_LOAD;
		else if (!gte)
			a = ACT_HOLD;
		else if (hit)
			a = ACT_RELOAD;
		else if (up)
			a = ACT_ADD;
		else
			a = ACT_SUB;
		return a;
	endfunction

	generate
		if (HAS_ANY)
		begin : g_inherit
			assign sample = bus.sample_tick;
			assign own_tick = 1'b0;
		end
		else
		begin : g_own
			ucnt_tick #(
				.PW(ucnt_pkg::PERIOD_W)
			) u_tick (
				.pclk(pclk),
				.presetn(presetn),
				.period(SAMPLE_P),
				.tick(own_tick)
			);
			assign sample = own_tick;
		end
	endgenerate

	// Absent clear and preset read as inactive, gate as open, direction as add
	assign clr_in = HAS_CLR ? bus.clear : 1'b0;
	assign pre_in = HAS_PRE ? bus.preset : 1'b0;
	assign gate_in = HAS_GATE ? bus.gate : 1'b1;
	assign up_in = HAS_DIR ? bus.dir : 1'b1;

	always_comb
	begin
		s_d = s_q;
		s_d.wrapped = 1'b0;
		s_d.reloaded = 1'b0;
		s_d.cfg_bad = BAD;
		act = pick_action(sample, clr_in, pre_in, gate_in, LIMITED && s_q.count == TERM_W, up_in);
		unique case (act)
			ACT_IDLE:
				s_d.count = s_q.count;
			ACT_CLEAR:
				s_d.count = INIT_W;
			ACT_LOAD:
				s_d.count = bus.preset_val;
			ACT_HOLD:
				s_d.count = s_q.count;
			ACT_RELOAD:
			begin
				s_d.count = INIT_W;
				s_d.reloaded = 1'b1;
			end
			ACT_ADD:
			begin
				s_d.count = s_q.count + STEP_W;
				s_d.wrapped = step_wraps(s_q.count, STEP_W, 1'b1);
			end
			ACT_SUB:
			begin
				s_d.count = s_q.count - STEP_W;
				s_d.wrapped = step_wraps(s_q.count, STEP_W, 1'b0);
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q.count <= INIT_W;
			s_q.wrapped <= 1'b0;
			s_q.reloaded <= 1'b0;
			s_q.cfg_bad <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign bus.count = s_q.count;
	assign count = s_q.count;
	assign wrapped = s_q.wrapped;
	assign reloaded = s_q.reloaded;
	assign cfg_bad = s_q.cfg_bad;
endmodule // ucnt_counter

// ===== rtl/ucnt_driver.sv
// Control end: APB registers that drive the counter's control inputs
`timescale 1ns/1ns
module ucnt_driver #(
	parameter int W = ucnt_pkg::DEF_W // Counter word length
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic [7:0] paddr, // APB byte address
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write when high
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	ucnt_if.drv bus // Counter control inputs
);
	localparam int PW = ucnt_pkg::PERIOD_W;

	typedef struct packed {
		logic clr;
		logic pre;
		logic gate;
		logic dir;
		logic [W-1:0] pval;
		logic [PW-1:0] period;
		logic [31:0] rdata;
		logic ready;
		logic err;
	} ucnt_drv_st_t;
	ucnt_drv_st_t s_q;
	ucnt_drv_st_t s_d;

	logic tick;
	logic setup;
	logic wr;
	logic [W+31:0] pval_rd;
	logic [W+31:0] cnt_rd;
	logic [W+31:0] pval_wr;

	// One tick gates the clear and preset strobes and is the sample qualifier, so all inputs share one sample period
	ucnt_tick #(
		.PW(PW)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.period(s_q.period),
		.tick(tick)
	);

	assign setup = psel && !penable;
	assign wr = psel && penable && s_q.ready && pwrite;
	assign pval_rd = {32'h00000000, s_q.pval};
	assign cnt_rd = {32'h00000000, bus.count};
	assign pval_wr = {{W{1'b0}}, pwdata};

	always_comb
	begin
		s_d = s_q;
		s_d.ready = setup;
		s_d.err = 1'b0;
		// Strobes are held until the sample tick that delivers them
		if (tick)
		begin
			s_d.clr = 1'b0;
			s_d.pre = 1'b0;
		end
		if (setup)
		begin
			s_d.rdata = 32'h00000000;
			unique case (paddr)
				ucnt_pkg::OFF_CTRL:
					s_d.rdata = {28'h0000000, s_q.dir, s_q.gate, s_q.pre, s_q.clr};
				ucnt_pkg::OFF_PRESET:
					s_d.rdata = pval_rd[31:0];
				ucnt_pkg::OFF_PERIOD:
					s_d.rdata = {{(32-PW){1'b0}}, s_q.period};
				ucnt_pkg::OFF_COUNT:
					s_d.rdata = cnt_rd[31:0];
				default:
					s_d.err = 1'b1;
			endcase
		end
		if (wr)
		begin
			if (paddr == ucnt_pkg::OFF_CTRL)
			begin
				// A strobe written in a tick cycle survives to the next tick
				s_d.clr = s_d.clr | pwdata[ucnt_pkg::CTRL_CLR];
				s_d.pre = s_d.pre | pwdata[ucnt_pkg::CTRL_PRE];
				s_d.gate = pwdata[ucnt_pkg::CTRL_GATE];
				s_d.dir = pwdata[ucnt_pkg::CTRL_DIR];
			end
			else if (paddr == ucnt_pkg::OFF_PRESET)
				s_d.pval = pval_wr[W-1:0];
			else if (paddr == ucnt_pkg::OFF_PERIOD)
				s_d.period = pwdata[PW-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q.clr <= ucnt_pkg::CTRL_RST[ucnt_pkg::CTRL_CLR];
			s_q.pre <= ucnt_pkg::CTRL_RST[ucnt_pkg::CTRL_PRE];
			s_q.gate <= ucnt_pkg::CTRL_RST[ucnt_pkg::CTRL_GATE];
			s_q.dir <= ucnt_pkg::CTRL_RST[ucnt_pkg::CTRL_DIR];
			s_q.pval <= '0;
			s_q.period <= ucnt_pkg::PERIOD_RST;
			s_q.rdata <= 32'h00000000;
			s_q.ready <= 1'b0;
			s_q.err <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign bus.clear = s_q.clr && tick;
	assign bus.preset = s_q.pre && tick;
	assign bus.preset_val = s_q.pval;
	assign bus.gate = s_q.gate;
	assign bus.dir = s_q.dir;
	assign bus.sample_tick = tick;
	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.err;
endmodule // ucnt_driver

// ===== dv/ucnt_properties.sv
// Checker for the control link between driver and counter
`timescale 1ns/1ns
module ucnt_properties #(
	parameter int W = 8,
	parameter logic [124:0] INIT = 125'h0,
	parameter logic [124:0] STEP = 125'h1,
	parameter logic [124:0] TERM = 125'h64
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic clear, // Local clear
	input wire logic preset, // Preset strobe
	input wire logic [W-1:0] preset_val, // Preset value
	input wire logic gate, // Count gate
	input wire logic dir, // Direction
	input wire logic sample_tick, // Sample qualifier
	input wire logic [W-1:0] count, // Count
	input wire logic wrapped, // Step overflow pulse
	input wire logic reloaded // Terminal reload pulse
);
	logic [W-1:0] up_nx;
	logic [W-1:0] dn_nx;
	assign up_nx = count + STEP[W-1:0];
	assign dn_nx = count - STEP[W-1:0];
	logic [W:0] up_ext;
	logic [W:0] dn_ext;
	logic up_cy;
	logic dn_cy;
	assign up_ext = {1'b0, count} + {1'b0, STEP[W-1:0]};
	assign dn_ext = {1'b0, count} - {1'b0, STEP[W-1:0]};
	assign up_cy = up_ext[W];
	assign dn_cy = dn_ext[W];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_step;
		sample_tick && !clear && !preset && gate && count != TERM[W-1:0];
	endsequence
	sequence s_hold;
		sample_tick && !clear && !preset && !gate;
	endsequence
	sequence s_reload;
		sample_tick && !clear && !preset && gate && count == TERM[W-1:0];
	endsequence
	AST_RST_INIT: assert property ($rose(presetn) |-> count == INIT[W-1:0])
		else $error("count not initial after reset");
	AST_CLEAR: assert property (sample_tick && clear |=> count == INIT[W-1:0])
		else $error("clear did not restore initial value");
	AST_PRESET: assert property (sample_tick && !clear && preset |=> count == $past(preset_val))
		else $error("preset value not loaded");
	AST_HOLD: assert property (s_hold |=> $stable(count))
		else $error("count moved with gate low");
	AST_UP: assert property (s_step ##0 dir |=> count == $past(up_nx) && !reloaded)
		else $error("count did not add step");
	AST_DOWN: assert property (s_step ##0 !dir |=> count == $past(dn_nx) && !reloaded)
		else $error("count did not subtract step");
	AST_RELOAD: assert property (s_reload |=> count == INIT[W-1:0] && reloaded && !wrapped)
		else $error("terminal value did not reload");
	AST_WRAP_UP: assert property (s_step ##0 dir |=> wrapped == $past(up_cy))
		else $error("wrap flag wrong on add");
	AST_WRAP_DOWN: assert property (s_step ##0 !dir |=> wrapped == $past(dn_cy))
		else $error("wrap flag wrong on subtract");
	AST_QUIET: assert property (!sample_tick |=> !wrapped && !reloaded)
		else $error("pulse outside a sample");
	AST_IDLE: assert property (!sample_tick |=> $stable(count))
		else $error("count moved outside a sample");
	AST_STROBE: assert property (clear || preset |-> sample_tick)
		else $error("strobe outside a sample");
endmodule // ucnt_properties

// ===== dv/configurable_up_down_counter_bench.sv
// Bench: driver and counter joined, with a reference model
`timescale 1ns/1ns
module configurable_up_down_counter_bench;
	localparam int W = 8;
	localparam int INI = 5;
	localparam int STP = 3;
	localparam int TRM = 20;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cfg_bad;
	logic [W-1:0] cnt_out;
	logic wrapped;
	logic reloaded;
	logic [31:0] rd;
	logic err;
	int num_errors = 0;
	int check_count = 0;
	int seed = 32'hB5F5;
	int cyc = 0;
	int last;
	int cnt = INI;
	ucnt_if #(.W(W)) link ();
	ucnt_driver #(.W(W)) ucnt_driver_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus(link));
	ucnt_counter #(.W(W), .MODE(ucnt_pkg::UCNT_LIMITED), .INIT(125'(INI)), .STEP(125'(STP)), .TERM(125'(TRM)),
		.HAS_CLR(1'b1), .HAS_PRE(1'b1), .HAS_GATE(1'b1), .HAS_DIR(1'b1)) ucnt_counter_i (.pclk(pclk),
		.presetn(presetn), .bus(link), .count(cnt_out), .wrapped(wrapped), .reloaded(reloaded),
		.cfg_bad(cfg_bad));
	ucnt_properties #(.W(W), .INIT(125'(INI)), .STEP(125'(STP)), .TERM(125'(TRM))) ucnt_properties_i (
		.pclk(pclk), .presetn(presetn), .clear(link.clear), .preset(link.preset), .preset_val(link.preset_val),
		.gate(link.gate), .dir(link.dir), .sample_tick(link.sample_tick), .count(link.count),
		.wrapped(wrapped), .reloaded(reloaded));
	always #5 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge pclk);
		end
		if (n == 50)
			num_errors++;
		rd = prdata;
		err = pslverr;
		last = cyc;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Write control c for a whole number of samples, write control 0, then compare the count
	task automatic op(input logic [3:0] c, input logic [31:0] pv, input int p);
		int e;
		int t0;
		int k;
		e = (p == 0) ? 1 : p;
		apb(ucnt_pkg::OFF_PERIOD, 1'b1, 32'(p));
		apb(ucnt_pkg::OFF_PRESET, 1'b1, pv);
		apb(ucnt_pkg::OFF_PRESET, 1'b0, 32'h0);
		check("preset reg", rd, {24'h0, pv[W-1:0]});
		apb(ucnt_pkg::OFF_CTRL, 1'b1, {28'h0, c});
		t0 = last;
		repeat (e * (3 + $unsigned($random(seed)) % 3) - 3) @(posedge pclk);
		apb(ucnt_pkg::OFF_CTRL, 1'b1, 32'h0);
		k = (last - t0) / e;
		for (int i = 0; i < k; i++)
		begin
			if (i == 0 && c[0])
				cnt = INI;
			else if (i == 0 && c[1])
				cnt = pv[W-1:0];
			else if (c[2])
				cnt = (cnt == TRM) ? INI : (c[3] ? cnt + STP : cnt - STP) & 255;
		end
		apb(ucnt_pkg::OFF_COUNT, 1'b0, 32'h0);
		check("count", rd, 32'(cnt));
		check("count port", 32'(cnt_out), 32'(cnt));
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		num_errors++;
		complete_run();
	end
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(ucnt_pkg::OFF_CTRL, 1'b0, 32'h0);
		check("ctrl reset", rd, ucnt_pkg::CTRL_RST);
		apb(ucnt_pkg::OFF_PERIOD, 1'b0, 32'h0);
		check("period reset", rd, 32'h1);
		op(4'h1, 32'h0, 1);
		op(4'hE, 32'hFE, 1);
		op(4'hE, 32'h11, 1);
		op(4'h6, 32'h01, 0);
		op(4'hF, 32'h77, 2);
		op(4'h8, 32'h33, 3);
		apb(ucnt_pkg::OFF_COUNT, 1'b1, 32'hAB);
		apb(ucnt_pkg::OFF_COUNT, 1'b0, 32'h0);
		check("count read only", rd, 32'(cnt));
		apb(8'h10, 1'b0, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h1);
		check("unmapped data", rd, 32'h0);
		repeat (40) op(4'($random(seed)), $random(seed), $unsigned($random(seed)) % 4);
		check("cfg bad", {31'h0, cfg_bad}, 32'h0);
		complete_run();
	end
endmodule // configurable_up_down_counter_bench
